// *** cpu_break_model.sv ***
// Far-side model: CPU break input and host word tally of the debug block
`default_nettype none
module cpu_break_model (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic fifoWrite,
	input wire logic breakReq,
	output logic [7:0] pushCount,
	output logic [7:0] breakCount
);
	timeunit 1ns;
	timeprecision 1ps;
	// Host keeps its own word tally, since the block never counts down
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pushCount <= 8'h00;
			breakCount <= 8'h00;
		end else begin
			pushCount <= pushCount + {7'h00, fifoWrite};
			breakCount <= breakCount + {7'h00, breakReq};
		end
	end
endmodule : cpu_break_model
`default_nettype wire

// *** debug_trigger_pkg.sv ***
// Constants and types shared by the debug trigger and status logic
`default_nettype none
package debug_trigger_pkg;
	// Register offsets on the plain register port
	localparam logic [2:0] ADDR_CONTROL = 3'h0;
	localparam logic [2:0] ADDR_TRIGGER = 3'h1;
	localparam logic [2:0] ADDR_STATUS = 3'h2;
	// Control register fields
	localparam int CTRL_ENABLE_BIT = 7;
	localparam int CTRL_RUN_BIT = 6;
	localparam int CTRL_BREAK_EN_BIT = 4;
	// Trigger configuration fields
	localparam int CFG_TYPE_BIT = 7;
	localparam int CFG_BEGIN_BIT = 6;
	localparam logic [7:0] CFG_WRITE_MASK = 8'hCF;
	localparam logic [7:0] CFG_RESET = 8'h00;
	// Status register fields
	localparam int STAT_MATCH_A_BIT = 7;
	localparam int STAT_MATCH_B_BIT = 6;
	localparam int STAT_RUN_ACTIVE_BIT = 5;
	// Trigger mode codes
	localparam logic [3:0] MODE_A_ONLY = 4'h0;
	localparam logic [3:0] MODE_A_OR_B = 4'h1;
	localparam logic [3:0] MODE_A_THEN_B = 4'h2;
	localparam logic [3:0] MODE_EVENT_B = 4'h3;
	localparam logic [3:0] MODE_A_EVENT_B = 4'h4;
	localparam logic [3:0] MODE_A_AND_B = 4'h5;
	localparam logic [3:0] MODE_A_NOT_B = 4'h6;
	localparam logic [3:0] MODE_INSIDE = 4'h7;
	localparam logic [3:0] MODE_OUTSIDE = 4'h8;
	// Capture depth in words
	localparam int FIFO_DEPTH = 8;
	// Run state, Gray coded along idle, wait, fill and ring
	typedef enum logic [1:0] {
		RS_IDLE = 2'b00,
		RS_WAIT = 2'b01,
		RS_FILL = 2'b11,
		RS_RING = 2'b10
	} run_state_t;
endpackage : debug_trigger_pkg
`default_nettype wire

// *** debug_trigger_status_logic.sv ***
// Trigger selection, capture sequencing and run status of the debug module
//
// What this block does
// - Trigger configuration always readable; writes only land while not armed.
// - Trigger configuration bits four and five read zero, never written.
// - Type bit clear triggers on access; set waits for tagged opcode execution.
// - Begin bit set: trigger starts storage; clear: circular fill until trigger.
// - Event-only modes ignore the begin bit and always run as begin trace.
// - Mode 0000 A only, 0001 A or B, 0010 A then B.
// - Mode 0011 stores each B event; 0100 stores B events after A.
// - Mode 0111 address inside A..B; 1000 below A or above B.
// - Modes 1001 to 1111 never trigger.
// - Match A flag cleared at run start, set on A match while armed.
// - Match B flag cleared at run start, set on B match while armed.
// - Run active flag mirrors run control bit while module enabled.
// - Run ends on full FIFO in begin trace, trigger in end trace.
// - Writing zero to run control or enable stops the run at once.
// - Valid word count cleared at run start, reports zero to eight words.
// - Valid word count never decrements when the FIFO is read.
// - Run status register is read-only; writes do nothing.
// - Break request on trigger in end trace, on full in begin trace.
// - Event-only modes store only the low byte; high byte reads zero.
`default_nettype none
module debug_trigger_status_logic #(
	parameter int DEPTH = debug_trigger_pkg::FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [7:0] regRdData,
	input wire logic accessValid,
	input wire logic addrEqA,
	input wire logic addrLtA,
	input wire logic addrEqB,
	input wire logic addrGtB,
	input wire logic dataEqB,
	input wire logic tagExec,
	input wire logic cofValid,
	output logic fifoWrite,
	output logic fifoLowOnly,
	output logic breakReq
);
	import debug_trigger_pkg::*;

	localparam logic [3:0] FULL_COUNT = 4'(DEPTH);

	typedef struct packed {
		run_state_t state;
		logic enable;
		logic break_request_enable;
		logic [7:0] cfg;
		logic matchAFlag;
		logic matchBFlag;
		logic [3:0] validWordCount;
		logic aSeen;
		logic pendA;
		logic pendB;
		logic pendT;
		logic [7:0] rdData;
		logic fifoWr;
		logic lowOnly;
		logic brk;
	} state_t;

	state_t s_q;
	state_t s_d;
	logic [3:0] mode;
	logic evMode;
	logic tagType;
	logic armed;
	logic rawA;
	logic rawB;
	logic condRaw;
	logic hitA;
	logic hitB;
	logic trig;
	logic store;
	logic startReq;
	logic [3:0] countInc;

	// Decode of the current configuration and of the bus access
	always_comb begin
		mode = s_q.cfg[3:0];
		evMode = (mode == MODE_EVENT_B) || (mode == MODE_A_EVENT_B);
		tagType = s_q.cfg[CFG_TYPE_BIT];
		armed = (s_q.state != RS_IDLE);
		rawA = accessValid & addrEqA;
		rawB = accessValid & addrEqB;
		countInc = s_q.validWordCount + 4'h1;
		startReq = regWrStb && (regAddr == ADDR_CONTROL) &&
			regWrData[CTRL_ENABLE_BIT] && regWrData[CTRL_RUN_BIT] && !armed;
	end

	// Trigger condition per mode, before tag qualification
	always_comb begin
		case (mode)
			MODE_A_ONLY: condRaw = rawA;
			MODE_A_OR_B: condRaw = rawA | rawB;
			MODE_A_THEN_B: condRaw = s_q.aSeen & rawB;
			MODE_EVENT_B: condRaw = rawB;
			MODE_A_EVENT_B: condRaw = s_q.aSeen & rawB;
			MODE_A_AND_B: condRaw = rawA & dataEqB;
			MODE_A_NOT_B: condRaw = rawA & !dataEqB;
			MODE_INSIDE: condRaw = accessValid & !addrLtA & !addrGtB;
			MODE_OUTSIDE: condRaw = accessValid & (addrLtA | addrGtB);
			default: condRaw = 1'b0;
		endcase
	end

	// Force uses the access itself; tag waits for the opcode to execute
	always_comb begin
		if (tagType) begin
			hitA = s_q.pendA & tagExec;
			hitB = s_q.pendB & tagExec;
			trig = s_q.pendT & tagExec;
		end else begin
			hitA = rawA;
			hitB = rawB;
			trig = condRaw;
		end
	end

	// Next state of the whole block
	always_comb begin
		s_d = s_q;
		s_d.rdData = 8'h00;
		s_d.fifoWr = 1'b0;
		s_d.brk = 1'b0;
		store = 1'b0;
		if (armed) begin
			// Tagged matches wait here until the opcode runs
			if (tagType) begin
				s_d.pendA = (s_q.pendA & !tagExec) | rawA;
				s_d.pendB = (s_q.pendB & !tagExec) | rawB;
				s_d.pendT = (s_q.pendT & !tagExec) | condRaw;
			end
			if (hitA) begin
				s_d.matchAFlag = 1'b1;
				s_d.aSeen = 1'b1;
			end
			if (hitB) begin
				s_d.matchBFlag = 1'b1;
			end
		end
		case (s_q.state)
			RS_WAIT: begin
				// Begin trace: trigger opens the capture window
				if (trig) begin
					s_d.state = RS_FILL;
				end
			end
			RS_FILL: begin
				// Event modes store on each event, others on change of flow
				store = evMode ? trig : cofValid;
				if (store) begin
					s_d.fifoWr = 1'b1;
					s_d.lowOnly = evMode;
					s_d.validWordCount = countInc;
					if (countInc == FULL_COUNT) begin
						s_d.state = RS_IDLE;
						s_d.brk = s_q.break_request_enable;
					end
				end
			end
			RS_RING: begin
				// End trace: ring keeps the last words, trigger closes it
				if (cofValid) begin
					store = 1'b1;
					s_d.fifoWr = 1'b1;
					s_d.lowOnly = 1'b0;
					if (s_q.validWordCount != FULL_COUNT) begin
						s_d.validWordCount = countInc;
					end
				end
				if (trig) begin
					s_d.state = RS_IDLE;
					s_d.brk = s_q.break_request_enable;
				end
			end
			default: begin
				s_d.state = RS_IDLE;
			end
		endcase
		// Register writes; the status register has no write path
		if (regWrStb) begin
			if (regAddr == ADDR_CONTROL) begin
				s_d.enable = regWrData[CTRL_ENABLE_BIT];
				s_d.break_request_enable = regWrData[CTRL_BREAK_EN_BIT];
				if (!regWrData[CTRL_ENABLE_BIT] ||
					!regWrData[CTRL_RUN_BIT]) begin
					s_d.state = RS_IDLE;
				end else if (startReq) begin
					// Run start clears flags, count and sequence memory
					s_d.matchAFlag = 1'b0;
					s_d.matchBFlag = 1'b0;
					s_d.validWordCount = 4'h0;
					s_d.aSeen = 1'b0;
					s_d.pendA = 1'b0;
					s_d.pendB = 1'b0;
					s_d.pendT = 1'b0;
					if (evMode) begin
						s_d.state = RS_FILL;
					end else if (s_q.cfg[CFG_BEGIN_BIT]) begin
						s_d.state = RS_WAIT;
					end else begin
						s_d.state = RS_RING;
					end
				end
			end else if (regAddr == ADDR_TRIGGER) begin
				if (!armed) begin
					s_d.cfg = regWrData & CFG_WRITE_MASK;
				end
			end else begin
				// Status is read-only; a write there changes nothing
				s_d.cfg = s_q.cfg;
			end
		end
		// A cleared enable never leaves a run behind
		if (!s_q.enable && !startReq) begin
			s_d.state = RS_IDLE;
		end
		// Read data stand only in the cycle after the strobe
		if (regRdStb) begin
			if (regAddr == ADDR_CONTROL) begin
				s_d.rdData[CTRL_ENABLE_BIT] = s_q.enable;
				s_d.rdData[CTRL_RUN_BIT] = armed;
				s_d.rdData[CTRL_BREAK_EN_BIT] = s_q.break_request_enable;
			end else if (regAddr == ADDR_TRIGGER) begin
				s_d.rdData = s_q.cfg & CFG_WRITE_MASK;
			end else if (regAddr == ADDR_STATUS) begin
				s_d.rdData[STAT_MATCH_A_BIT] = s_q.matchAFlag;
				s_d.rdData[STAT_MATCH_B_BIT] = s_q.matchBFlag;
				s_d.rdData[STAT_RUN_ACTIVE_BIT] = armed;
				s_d.rdData[3:0] = s_q.validWordCount;
			end else begin
				s_d.rdData = 8'h00;
			end
		end
	end

	// Single register stage for all state
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign regRdData = s_q.rdData;
	assign fifoWrite = s_q.fifoWr;
	assign fifoLowOnly = s_q.lowOnly;
	assign breakReq = s_q.brk;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	// Configuration frozen while a run is armed
	cfg_locked_a: assert property (
		(regWrStb && regAddr == ADDR_TRIGGER && armed) |=> $stable(s_q.cfg))
		else $error("trigger config changed while armed");

	// Reserved configuration bits always read zero
	cfg_reserved_a: assert property (
		(regRdStb && regAddr == ADDR_TRIGGER) |=> regRdData[5:4] == 2'b00)
		else $error("reserved trigger bits read non-zero");

	// Force trigger in end trace ends the run next cycle
	force_trig_a: assert property (
		(s_q.state == RS_RING && !tagType && mode == MODE_A_ONLY && rawA &&
		!regWrStb) |=> s_q.state == RS_IDLE)
		else $error("force trigger did not end run");

	// Event modes always start as begin trace
	event_begin_a: assert property (
		(startReq && evMode) |=> s_q.state == RS_FILL)
		else $error("event mode did not start filling");

	// Begin select picks waiting or ring
	begin_sel_a: assert property (
		(startReq && !evMode) |=>
		s_q.state == ($past(s_q.cfg[CFG_BEGIN_BIT]) ? RS_WAIT : RS_RING))
		else $error("wrong capture start state");

	// Unused modes never end a ring capture
	no_trig_a: assert property (
		(s_q.state == RS_RING && mode > MODE_OUTSIDE && !regWrStb &&
		s_q.enable) |=> s_q.state == RS_RING)
		else $error("reserved mode produced trigger");

	// Run start clears both match flags and the count
	start_clear_a: assert property (
		startReq |=> (!s_q.matchAFlag && !s_q.matchBFlag &&
		s_q.validWordCount == 4'h0))
		else $error("run start left stale status");

	// Status read shows the armed state of the cycle before
	run_flag_read_a: assert property (
		(regRdStb && regAddr == ADDR_STATUS) |=>
		regRdData[STAT_RUN_ACTIVE_BIT] == $past(armed))
		else $error("run active flag not mirrored");

	// Eighth stored word closes a begin trace with break
	fill_done_a: assert property (
		(s_q.state == RS_FILL && store &&
		s_q.validWordCount == FULL_COUNT - 4'h1 && !regWrStb) |=>
		(s_q.state == RS_IDLE && breakReq == $past(s_q.break_request_enable)))
		else $error("full FIFO did not end run");

	// Stop write ends the run
	stop_write_a: assert property (
		(regWrStb && regAddr == ADDR_CONTROL && !regWrData[CTRL_RUN_BIT])
		|=> !armed)
		else $error("stop write ignored");

	// A cleared enable leaves nothing armed
	enable_off_a: assert property (
		(!s_q.enable && !startReq) |=> !armed)
		else $error("run survived cleared enable");

	// Count stays put between runs and never passes depth
	count_hold_a: assert property (
		(!armed && !startReq) |=> $stable(s_q.validWordCount) &&
		s_q.validWordCount <= FULL_COUNT)
		else $error("valid count moved while idle");

	// Saturated ring count never rolls back to zero
	ring_sat_a: assert property (
		(s_q.state == RS_RING && s_q.validWordCount == FULL_COUNT) |=>
		s_q.validWordCount == FULL_COUNT)
		else $error("ring count rolled over");

	// A write to the status offset moves no field
	status_ro_a: assert property (
		(regWrStb && regAddr == ADDR_STATUS && !armed) |=>
		$stable({s_q.matchAFlag, s_q.matchBFlag, s_q.validWordCount,
		s_q.cfg}))
		else $error("status write changed state");

	// Matches seen while armed raise their flags
	flag_a_set_a: assert property (
		(armed && hitA) |=> s_q.matchAFlag)
		else $error("match A flag not set");
	flag_b_set_a: assert property (
		(armed && hitB) |=> s_q.matchBFlag)
		else $error("match B flag not set");

	// Begin trace stores nothing before its trigger
	wait_store_a: assert property (
		s_q.state == RS_WAIT |=> !fifoWrite)
		else $error("word stored before trigger");

	// Break pulse only comes with the end of a run
	brk_end_a: assert property (
		breakReq |-> !armed)
		else $error("break request while still armed");

	// Low-byte-only marker follows event modes
	low_only_a: assert property (
		(s_q.state == RS_FILL && store) |=> fifoLowOnly == $past(evMode))
		else $error("low byte marker wrong");

	// Main scenarios worth seeing in a run
	full_run_c: cover property (s_q.state == RS_FILL ##1 breakReq);
	ring_end_c: cover property (s_q.state == RS_RING && trig);
	ring_wrap_c: cover property (s_q.state == RS_RING &&
		s_q.validWordCount == FULL_COUNT);
	tag_hit_c: cover property (armed && tagType && trig);
	event_run_c: cover property (s_q.state == RS_FILL && evMode && store);
endmodule : debug_trigger_status_logic
`default_nettype wire

// *** debug_trigger_status_logic_bench.sv ***
// Self-checking bench for the debug trigger and status logic
`default_nettype none
module debug_trigger_status_logic_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import debug_trigger_pkg::*;
	// Match vectors: access, eqA, ltA, eqB, gtB, dataEqB, tag, cof
	localparam logic [7:0] A_HIT = 8'hC0;
	localparam logic [7:0] B_HIT = 8'h90;
	localparam logic [7:0] COF = 8'h01;
	localparam logic [7:0] TAG = 8'h02;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [2:0] regAddr = 3'h0;
	logic [7:0] regWrData = 8'h00;
	logic regWrStb = 1'b0;
	logic regRdStb = 1'b0;
	logic accessValid = 1'b0;
	logic [4:0] hit = 5'h00;
	logic tagExec = 1'b0;
	logic cofValid = 1'b0;
	logic [7:0] regRdData, pushCount, breakCount, p0, b0;
	logic fifoWrite, fifoLowOnly, breakReq;
	int failCount = 0;
	int checks = 0;
	// Clock at 40 MHz
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	debug_trigger_status_logic #(.DEPTH(FIFO_DEPTH)) uut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
		.regRdData(regRdData), .accessValid(accessValid),
		.addrEqA(hit[4]), .addrLtA(hit[3]), .addrEqB(hit[2]),
		.addrGtB(hit[1]), .dataEqB(hit[0]), .tagExec(tagExec),
		.cofValid(cofValid), .fifoWrite(fifoWrite),
		.fifoLowOnly(fifoLowOnly), .breakReq(breakReq));
	cpu_break_model far (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.fifoWrite(fifoWrite), .breakReq(breakReq),
		.pushCount(pushCount), .breakCount(breakCount));
	task automatic expect8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			failCount++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : expect8
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge clk_sys);
		regWrStb <= 1'b0;
	endtask : wr
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge clk_sys);
		regRdStb <= 1'b0;
		#1;
		expect8(regRdData, exp);
	endtask : rd
	task automatic drive(input logic [7:0] v);
		@(posedge clk_sys);
		{accessValid, hit, tagExec, cofValid} <= v;
		@(posedge clk_sys);
		{accessValid, hit, tagExec, cofValid} <= 8'h00;
	endtask : drive
	task automatic snap();
		#1;
		p0 = pushCount;
		b0 = breakCount;
	endtask : snap
	// Pulses land one cycle late, the model counts them one edge later
	task automatic counts(input logic [7:0] np, input logic [7:0] nb);
		repeat (2) @(posedge clk_sys);
		#1;
		expect8(pushCount - p0, np);
		expect8(breakCount - b0, nb);
	endtask : counts
	task automatic trial(input logic [7:0] cfg, input logic [7:0] v1,
		input logic [7:0] v2, input logic [7:0] brk);
		wr(ADDR_CONTROL, 8'h80);
		wr(ADDR_TRIGGER, cfg);
		wr(ADDR_CONTROL, 8'hD0);
		snap();
		drive(v1);
		drive(v2);
		counts(8'h00, brk);
		$display("trial cfg %h done", cfg);
	endtask : trial
	task automatic t_regs();
		rd(ADDR_TRIGGER, 8'h00);
		rd(3'h5, 8'h00);
		wr(ADDR_TRIGGER, 8'hFF);
		rd(ADDR_TRIGGER, 8'hCF);
		wr(ADDR_STATUS, 8'hFF);
		rd(ADDR_STATUS, 8'h00);
		wr(ADDR_CONTROL, 8'hC0);
		rd(ADDR_STATUS, 8'h20);
		rd(ADDR_CONTROL, 8'hC0);
		wr(ADDR_TRIGGER, 8'h00);
		rd(ADDR_TRIGGER, 8'hCF);
		wr(ADDR_CONTROL, 8'h80);
		rd(ADDR_STATUS, 8'h00);
		wr(ADDR_CONTROL, 8'hC0);
		wr(ADDR_CONTROL, 8'h40);
		rd(ADDR_STATUS, 8'h00);
		$display("register test done");
	endtask : t_regs
	task automatic t_modes();
		trial(8'h00, A_HIT, 8'h00, 8'h01);
		trial(8'h01, B_HIT, 8'h00, 8'h01);
		trial(8'h02, A_HIT, B_HIT, 8'h01);
		trial(8'h02, B_HIT, A_HIT, 8'h00);
		trial(8'h05, 8'hC4, 8'h00, 8'h01);
		trial(8'h05, A_HIT, 8'h00, 8'h00);
		trial(8'h06, A_HIT, 8'h00, 8'h01);
		trial(8'h07, 8'h80, 8'h00, 8'h01);
		trial(8'h07, 8'hA0, 8'h00, 8'h00);
		trial(8'h08, 8'h88, 8'h00, 8'h01);
		trial(8'h08, A_HIT, 8'h00, 8'h00);
		for (int m = 9; m < 16; m++) begin
			trial(8'(m), A_HIT, B_HIT, 8'h00);
		end
		trial(8'h80, A_HIT, 8'h00, 8'h00);
		trial(8'h80, A_HIT, TAG, 8'h01);
		$display("mode test done");
	endtask : t_modes
	task automatic t_capture();
		// End trace: three words, then the trigger ends the run
		wr(ADDR_TRIGGER, 8'h00);
		wr(ADDR_CONTROL, 8'hD0);
		snap();
		repeat (3) drive(COF);
		drive(A_HIT);
		counts(8'h03, 8'h01);
		rd(ADDR_STATUS, 8'h83);
		rd(ADDR_STATUS, 8'h83);
		wr(ADDR_CONTROL, 8'hC0);
		repeat (10) drive(COF);
		drive(A_HIT);
		rd(ADDR_STATUS, 8'h88);
		// Begin trace: words before the trigger are not stored
		wr(ADDR_TRIGGER, 8'h40);
		wr(ADDR_CONTROL, 8'hD0);
		snap();
		repeat (2) drive(COF);
		drive(A_HIT);
		counts(8'h00, 8'h00);
		rd(ADDR_STATUS, 8'hA0);
		repeat (8) drive(COF);
		counts(8'h08, 8'h01);
		rd(ADDR_STATUS, 8'h88);
		rd(ADDR_CONTROL, 8'h90);
		$display("capture test done");
	endtask : t_capture
	task automatic t_events();
		// End-trace setting is overridden: eight stores end the run
		wr(ADDR_TRIGGER, 8'h03);
		wr(ADDR_CONTROL, 8'hD0);
		snap();
		repeat (8) drive(B_HIT);
		counts(8'h08, 8'h01);
		expect8({7'h00, fifoLowOnly}, 8'h01);
		rd(ADDR_STATUS, 8'h48);
		wr(ADDR_TRIGGER, 8'h04);
		wr(ADDR_CONTROL, 8'hC0);
		snap();
		drive(B_HIT);
		drive(A_HIT);
		repeat (2) drive(B_HIT);
		counts(8'h02, 8'h00);
		wr(ADDR_CONTROL, 8'h80);
		// A ring store after an event run drops the low-only marker
		wr(ADDR_TRIGGER, 8'h00);
		wr(ADDR_CONTROL, 8'hC0);
		snap();
		drive(COF);
		counts(8'h01, 8'h00);
		expect8({7'h00, fifoLowOnly}, 8'h00);
		wr(ADDR_CONTROL, 8'h80);
		$display("event test done");
	endtask : t_events
	// Reset in mid-run returns every register to its idle value
	task automatic t_reset();
		wr(ADDR_TRIGGER, 8'h40);
		wr(ADDR_CONTROL, 8'hD0);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(ADDR_STATUS, 8'h00);
		rd(ADDR_TRIGGER, 8'h00);
		rd(ADDR_CONTROL, 8'h00);
		$display("reset test done");
	endtask : t_reset
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, failCount);
		if (failCount == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up
	// Main sequence after two cycles of reset
	initial begin
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_regs();
		t_modes();
		t_capture();
		t_events();
		t_reset();
		wrap_up();
	end
	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_sys);
		failCount++;
		$display("mismatch at %0t: watchdog expired", $time);
		wrap_up();
	end
endmodule : debug_trigger_status_logic_bench
`default_nettype wire
